// File: src/gci_ctrl.sv
// controller side of the instrument bus interface: registers, polls,
// service request interrupt and passing of control
// assumes bus lines arrive asynchronous and open drain lines resolve outside
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module gci_ctrl
  import gci_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic irq_o,
  input wire logic sysctl_i,
  input wire logic srq_i,
  input wire logic ifc_i,
  input wire logic [7:0] dio_i,
  input wire logic dav_i,
  output logic [7:0] dio_o,
  output logic dio_oe_o,
  output logic atn_o,
  output logic eoi_o,
  output logic dav_o
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [11:0] sync1;  // first stage, read only by sync2
  logic [11:0] sync2;  // second stage, safe for logic
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1 <= 12'h000;
      sync2 <= 12'h000;
    end else begin
      sync1 <= {sysctl_i, srq_i, ifc_i, dav_i, dio_i};
      sync2 <= sync1;
    end
  end
  logic s_sys, s_srq, s_ifc, s_dav;
  logic [7:0] s_dio;
  assign {s_sys, s_srq, s_ifc, s_dav, s_dio} = sync2;

  // ****************************************
  // register state
  // ****************************************
  logic strap_done;      // strap caught after reset release
  logic [1:0] strap_age; // edges since release, until sync settles
  logic sys_ctl;         // system controller strap
  logic active;          // active controller role
  logic [4:0] my_addr;   // primary address
  logic [15:0] mask;     // interrupt enable mask
  logic [15:0] cause;    // logged causes
  logic locked;          // interrupt lockout until serviced
  logic [7:0] result;    // last poll byte
  logic refused;         // last command refused
  logic busy;            // sequencer running
  logic next_strap_done, next_sys_ctl, next_active, next_locked;
  logic [1:0] next_strap_age;
  logic next_refused;
  logic [4:0] next_my_addr;
  logic [15:0] next_mask, next_cause, next_rdata;
  logic [7:0] next_result;
  logic next_irq;
  logic [15:0] ev;       // raw events this cycle
  logic go;              // command accepted
  logic [2:0] go_cmd;
  logic [4:0] go_dev;
  logic seq_result_v;    // sequencer delivers a poll byte
  logic [7:0] seq_result;
  logic seq_pass_done;   // control handed over

  // events: srq is sampled each cycle as a level, short pulses vanish
  always_comb begin
    ev = 16'h0000;
    ev[GCI_BIT_SRQ] = s_srq;
    ev[GCI_BIT_IFC] = s_ifc;
    ev[GCI_BIT_ACTIVE_EV] = s_ifc & sys_ctl & ~active;
  end

  // next values of the register group
  always_comb begin
    next_strap_done = strap_done;
    next_strap_age = strap_age;
    next_sys_ctl = sys_ctl;
    next_my_addr = my_addr;
    next_active = active;
    next_mask = mask;
    next_cause = cause;
    next_locked = locked;
    next_result = result;
    next_refused = refused;
    next_rdata = 16'h0000;
    go = 1'b0;
    go_cmd = wdata_i[10:8];
    go_dev = wdata_i[4:0];
    // strap taken once after release; address defaults follow it
    // waits for the synchroniser, else the reset zero would be taken
    if (!strap_done) begin
      next_strap_age = strap_age + 2'd1;
      if (strap_age == 2'(GCI_SYNC_CYC)) begin
        next_strap_done = 1'b1;
        next_sys_ctl = s_sys;
        next_active = s_sys;
        next_my_addr = s_sys ? GCI_ADDR_SYS : GCI_ADDR_NSYS;
      end
    end
    if (s_ifc && sys_ctl)
      next_active = 1'b1;
    if (seq_pass_done)
      next_active = 1'b0;
    if (seq_result_v)
      next_result = seq_result;
    // reading the cause register services the interrupt
    if (rd_i && addr_i == GCI_REG_CAUSE) begin
      next_cause = 16'h0000;
      next_locked = 1'b0;
    end
    if (wr_i) begin
      case (addr_i)
        GCI_REG_CTRL: begin
          // modulo 32 is the low five bits; 31 folds to 30
          next_my_addr = (wdata_i[4:0] == GCI_ADDR_UNUSED) ?
                         GCI_ADDR_MAX : wdata_i[4:0];
        end
        GCI_REG_CAUSE: begin
          next_mask = wdata_i;
          next_locked = 1'b0;
        end
        GCI_REG_CMD: begin
          // refuse without controller role, busy, or bad address
          if (busy || !active ||
              ((go_cmd == GCI_CMD_SPOLL || go_cmd == GCI_CMD_PASS ||
                go_cmd == GCI_CMD_PPU_DEV) &&
               go_dev == GCI_ADDR_UNUSED)) begin
            next_refused = 1'b1;
          end else begin
            next_refused = 1'b0;
            go = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // lockout: one logged unmasked event blocks the rest; set wins
    if (!locked && |(ev & mask)) begin
      next_cause = next_cause | (ev & mask);
      next_locked = 1'b1;
    end
    if (rd_i) begin
      case (addr_i)
        GCI_REG_CTRL: next_rdata = {8'h00, sys_ctl, active, 1'b0,
                                    my_addr};
        GCI_REG_CAUSE: next_rdata = cause;
        GCI_REG_MASK: next_rdata = mask;
        GCI_REG_RESULT: next_rdata = {6'h00, busy, refused, result};
        default: next_rdata = 16'h0000;
      endcase
    end
    next_irq = |(next_cause & next_mask);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_done <= 1'b0;
      strap_age <= 2'd0;
      sys_ctl <= 1'b0;
      active <= 1'b0;
      my_addr <= GCI_ADDR_NSYS;
      mask <= GCI_MASK_RST;
      cause <= 16'h0000;
      locked <= 1'b0;
      result <= 8'h00;
      refused <= 1'b0;
      rdata_o <= 16'h0000;
      irq_o <= 1'b0;
    end else begin
      strap_done <= next_strap_done;
      strap_age <= next_strap_age;
      sys_ctl <= next_sys_ctl;
      active <= next_active;
      my_addr <= next_my_addr;
      mask <= next_mask;
      cause <= next_cause;
      locked <= next_locked;
      result <= next_result;
      refused <= next_refused;
      rdata_o <= next_rdata;
      irq_o <= next_irq;
    end
  end

  // ****************************************
  // bus sequencer
  // ****************************************
  // byte list per command; the bus handshake is simplified to a timed
  // strobe since acceptor timing lies outside this block
  gci_state_t state, next_state;
  logic [2:0] cmd, next_cmd;
  logic [4:0] dev, next_dev;
  logic [1:0] idx, next_idx;
  logic [4:0] cnt, next_cnt;
  logic [7:0] nb_dio, next_dio;
  logic next_oe, next_atn, next_eoi, next_dav;
  logic [7:0] bytev;    // byte to send at idx
  logic lastb;          // idx is the final byte

  always_comb begin
    bytev = 8'h00;
    lastb = 1'b1;
    case (cmd)
      GCI_CMD_PPU_ALL: bytev = GCI_BUS_PPU;
      GCI_CMD_PPU_DEV: begin
        // listen address the device, then disable its response
        lastb = (idx == 2'd3);
        case (idx)
          2'd0: bytev = GCI_BUS_UNL;
          2'd1: bytev = GCI_BUS_LAG | {3'h0, dev};
          2'd2: bytev = GCI_BUS_PPC;
          default: bytev = GCI_BUS_PPD;
        endcase
      end
      GCI_CMD_SPOLL: begin
        lastb = (idx == 2'd2);
        case (idx)
          2'd0: bytev = GCI_BUS_UNL;
          2'd1: bytev = GCI_BUS_SPE;
          default: bytev = GCI_BUS_TAG | {3'h0, dev};
        endcase
      end
      GCI_CMD_PASS: begin
        lastb = (idx == 2'd1);
        bytev = (idx == 2'd0) ? (GCI_BUS_TAG | {3'h0, dev})
                              : GCI_BUS_TCT;
      end
      default: bytev = 8'h00;
    endcase
  end

  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_dev = dev;
    next_idx = idx;
    next_cnt = cnt;
    next_dio = nb_dio;
    next_oe = dio_oe_o;
    next_atn = atn_o;
    next_eoi = eoi_o;
    next_dav = dav_o;
    seq_result_v = 1'b0;
    seq_result = s_dio;
    seq_pass_done = 1'b0;
    case (state)
      GCI_IDLE: begin
        if (go) begin
          next_cmd = go_cmd;
          next_dev = go_dev;
          next_idx = 2'd0;
          next_cnt = 5'd0;
          if (go_cmd == GCI_CMD_PARALLEL_STATUS_QUERY) begin
            // identify: atn with eoi, devices drive their lines
            next_atn = 1'b1;
            next_eoi = 1'b1;
            next_state = GCI_PP_WAIT;
          end else begin
            next_state = GCI_CMD_BYTE;
          end
        end
      end
      GCI_PP_WAIT: begin
        next_cnt = cnt + 5'd1;
        if (cnt == 5'(GCI_PARALLEL_STATUS_QUERY_CYC - 1)) begin
          seq_result_v = 1'b1;
          next_atn = 1'b0;
          next_eoi = 1'b0;
          next_state = GCI_DONE;
        end
      end
      GCI_CMD_BYTE: begin
        next_atn = 1'b1;
        next_oe = 1'b1;
        next_dio = bytev;
        next_dav = 1'b1;
        next_cnt = 5'd0;
        next_state = GCI_CMD_HOLD;
      end
      GCI_CMD_HOLD: begin
        next_cnt = cnt + 5'd1;
        if (cnt == 5'(GCI_BYTE_CYC - 1)) begin
          next_dav = 1'b0;
          next_oe = 1'b0;
          next_idx = idx + 2'd1;
          if (!lastb)
            next_state = GCI_CMD_BYTE;
          else if (cmd == GCI_CMD_SPOLL) begin
            next_atn = 1'b0;   // release so the talker sends status
            next_cnt = 5'd0;
            next_state = GCI_SP_READ;
          end else begin
            next_atn = 1'b0;
            seq_pass_done = (cmd == GCI_CMD_PASS);
            next_state = GCI_DONE;
          end
        end
      end
      GCI_SP_READ: begin
        // one full status byte from the addressed device; our own strobe
        // and last byte linger in the synchroniser, so let it drain first
        if (cnt != 5'(GCI_SYNC_CYC)) begin
          next_cnt = cnt + 5'd1;
        end else if (s_dav) begin
          seq_result_v = 1'b1;
          next_dio = GCI_BUS_SPD;
          next_oe = 1'b1;
          next_atn = 1'b1;
          next_dav = 1'b1;
          next_cnt = 5'd0;
          next_state = GCI_SP_END;
        end
      end
      GCI_SP_END: begin
        next_cnt = cnt + 5'd1;
        if (cnt == 5'(GCI_BYTE_CYC - 1)) begin
          next_dav = 1'b0;
          next_oe = 1'b0;
          next_atn = 1'b0;
          next_state = GCI_DONE;
        end
      end
      GCI_DONE: next_state = GCI_IDLE;
      default: next_state = GCI_IDLE;
    endcase
    // interface clear from the system controller aborts the sequence
    if (s_ifc) begin
      next_state = GCI_IDLE;
      next_oe = 1'b0;
      next_atn = 1'b0;
      next_eoi = 1'b0;
      next_dav = 1'b0;
    end
  end
  assign busy = (state != GCI_IDLE);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= GCI_IDLE;
      cmd <= 3'h0;
      dev <= 5'h00;
      idx <= 2'd0;
      cnt <= 5'd0;
      nb_dio <= 8'h00;
      dio_o <= 8'h00;
      dio_oe_o <= 1'b0;
      atn_o <= 1'b0;
      eoi_o <= 1'b0;
      dav_o <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      dev <= next_dev;
      idx <= next_idx;
      cnt <= next_cnt;
      nb_dio <= next_dio;
      dio_o <= next_dio;
      dio_oe_o <= next_oe;
      atn_o <= next_atn;
      eoi_o <= next_eoi;
      dav_o <= next_dav;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_MASK_LOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == GCI_REG_CAUSE |=> mask == $past(wdata_i))
    else $error("mask not loaded");
  AST_LOCKOUT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    locked && !(rd_i && addr_i == GCI_REG_CAUSE) && !wr_i
    |=> cause == $past(cause))
    else $error("cause changed while locked");
  AST_CTRL_READ: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_i && addr_i == GCI_REG_CTRL |=> rdata_o[5] == 1'b0 &&
    rdata_o[7] == $past(sys_ctl) && rdata_o[6] == $past(active))
    else $error("controller status read wrong");
  AST_PP_ROLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_i && addr_i == GCI_REG_CMD && !active |-> !go ##1 refused)
    else $error("command taken without controller role");
  AST_ADDR_FOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    my_addr != GCI_ADDR_UNUSED)
    else $error("address 31 in use");
  AST_SRQ_IRQ: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !locked && mask[GCI_BIT_SRQ] && s_srq ##1 mask[GCI_BIT_SRQ]
    |=> irq_o)
    else $error("service request did not interrupt");
  AST_SERVICE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_i && addr_i == GCI_REG_CAUSE && !(|(ev & mask)) |=> !locked)
    else $error("read did not release lockout");
  AST_PASS_DROP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    seq_pass_done && !s_ifc |=> !active)
    else $error("role kept after passing control");
  AST_DEFAULT_ADDR: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !strap_done && strap_age == 2'(GCI_SYNC_CYC)
    |=> my_addr == ($past(s_sys) ? GCI_ADDR_SYS
                                             : GCI_ADDR_NSYS))
    else $error("power-on address wrong");
endmodule

// File: inc/gci_pkg.sv
// constants, register map and timing counts of the controller interface
// assumes one 10 MHz clock and a plain strobe register port
// How it works
// - mask load writes enable register four
// - mask bit 1 enables service requests
// - service request sampled as a level
// - one logged interrupt locks out others
// - parallel poll returns one eight-bit byte
// - parallel poll only as active controller
// - unconfigure all or only addressed devices
// - serial poll needs controller and address
// - status bit 7 shows system controller
// - status bit 6 shows active controller
// - bits 4..0 address, bit 5 zero
// - power-on address 21 or 20
// - address write taken modulo 32, 31 unused
// - pass control: talk address then take control
// - sixteen-bit mask matches cause register
package gci_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] GCI_REG_CTRL = 4'h3;    // state and address
  localparam logic [3:0] GCI_REG_CAUSE = 4'h4;   // read: cause, write: mask
  localparam logic [3:0] GCI_REG_MASK = 4'h5;    // mask readback
  localparam logic [3:0] GCI_REG_CMD = 4'h6;     // command and target
  localparam logic [3:0] GCI_REG_RESULT = 4'h7;  // poll result and flags
  // ****************************************
  // field positions and values
  // ****************************************
  localparam int GCI_BIT_SYSCTL = 7;
  localparam int GCI_BIT_ACTIVE = 6;
  localparam int GCI_BIT_SRQ = 1;
  localparam int GCI_BIT_IFC = 0;
  localparam int GCI_BIT_ACTIVE_EV = 15;
  localparam logic [4:0] GCI_ADDR_SYS = 5'h15;   // 21
  localparam logic [4:0] GCI_ADDR_NSYS = 5'h14;  // 20
  localparam logic [4:0] GCI_ADDR_UNUSED = 5'h1f;
  localparam logic [4:0] GCI_ADDR_MAX = 5'h1e;
  localparam logic [15:0] GCI_MASK_RST = 16'h0000;
  // command codes in the command register bits 10:8
  localparam logic [2:0] GCI_CMD_PARALLEL_STATUS_QUERY = 3'h1;
  localparam logic [2:0] GCI_CMD_PPU_ALL = 3'h2;
  localparam logic [2:0] GCI_CMD_PPU_DEV = 3'h3;
  localparam logic [2:0] GCI_CMD_SPOLL = 3'h4;
  localparam logic [2:0] GCI_CMD_PASS = 3'h5;
  // bus command bytes
  localparam logic [7:0] GCI_BUS_PPU = 8'h15;
  localparam logic [7:0] GCI_BUS_PPC = 8'h05;
  localparam logic [7:0] GCI_BUS_PPD = 8'h70;
  localparam logic [7:0] GCI_BUS_SPE = 8'h18;
  localparam logic [7:0] GCI_BUS_SPD = 8'h19;
  localparam logic [7:0] GCI_BUS_TCT = 8'h09;
  localparam logic [7:0] GCI_BUS_UNL = 8'h3f;
  localparam logic [7:0] GCI_BUS_LAG = 8'h20;
  localparam logic [7:0] GCI_BUS_TAG = 8'h40;
  // ****************************************
  // timing
  // ****************************************
  localparam int GCI_CLK_NS = 100;
  localparam int GCI_PARALLEL_STATUS_QUERY_NS = 2000;  // least poll settle time
  localparam int GCI_PARALLEL_STATUS_QUERY_CYC = (GCI_PARALLEL_STATUS_QUERY_NS + GCI_CLK_NS - 1) / GCI_CLK_NS;
  localparam int GCI_BYTE_NS = 1000;   // least byte hold time
  localparam int GCI_BYTE_CYC = (GCI_BYTE_NS + GCI_CLK_NS - 1) / GCI_CLK_NS;
  localparam int GCI_SYNC_CYC = 2;     // synchroniser depth in cycles
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    GCI_IDLE, GCI_PP_WAIT, GCI_CMD_BYTE, GCI_CMD_HOLD, GCI_SP_READ,
    GCI_SP_END, GCI_DONE
  } gci_state_t;
endpackage

// File: bench/gci_bus_model.sv
// instruments on the far side: two poll responders, one serial talker
// assumes the design drives registered, active-high bus lines
`timescale 1ns/1ps
module gci_bus_model
  import gci_pkg::*;
(
  input wire logic clk_i,
  input wire logic atn_i,
  input wire logic eoi_i,
  input wire logic dav_i,
  input wire logic [7:0] dio_i,
  output logic [7:0] dio_o,
  output logic dav_o,
  output logic srq_o
);
  // ****************************************
  // device set-up, fixed per responder
  // ****************************************
  localparam logic [4:0] DEV_A [0:1] = '{5'h05, 5'h09};
  localparam logic [2:0] LINE [0:1] = '{3'h0, 3'h7};
  localparam logic SENSE [0:1] = '{1'b1, 1'b0};
  localparam logic IST [0:1] = '{1'b1, 1'b0};
  localparam logic [7:0] ST_BYTE = 8'h41;  // status byte of address 9
  logic on_q [0:1];      // responder configured
  logic [7:0] log_q [0:7];  // command bytes seen
  int n_log;
  logic [4:0] talker;
  logic [4:0] listener;
  logic sp_mode;
  logic dav_q;
  initial begin
    on_q = '{1'b0, 1'b0};
    n_log = 0;
    talker = 5'h1f;
    listener = 5'h1f;
    sp_mode = 1'b0;
    dav_q = 1'b0;
    srq_o = 1'b0;
  end
  // stands in for a configure command from elsewhere
  task automatic configure(input int d);
    on_q[d] = 1'b1;
  endtask
  // ****************************************
  // command byte decode on each dav rise under attention
  // ****************************************
  always @(posedge clk_i) begin
    dav_q <= dav_i;
    if (dav_i && !dav_q && atn_i) begin
      log_q[n_log[2:0]] <= dio_i;
      n_log <= n_log + 1;
      if (dio_i == GCI_BUS_UNL) begin
        listener <= 5'h1f;
      end else if (dio_i[7:5] == 3'b001) begin
        listener <= dio_i[4:0];
      end else if (dio_i[7:5] == 3'b010) begin
        talker <= dio_i[4:0];
      end else if (dio_i == GCI_BUS_PPU) begin
        on_q <= '{1'b0, 1'b0};
      end else if (dio_i == GCI_BUS_PPD) begin
        for (int d = 0; d < 2; d++) begin
          if (DEV_A[d] == listener) begin
            on_q[d] <= 1'b0;
          end
        end
      end else if (dio_i == GCI_BUS_SPE) begin
        sp_mode <= 1'b1;
      end else if (dio_i == GCI_BUS_SPD) begin
        sp_mode <= 1'b0;
      end
    end
  end
  // ****************************************
  // answers; released lines are terminated to false
  // ****************************************
  always_comb begin
    dio_o = 8'h00;
    dav_o = 1'b0;
    if (atn_i && eoi_i) begin
      for (int d = 0; d < 2; d++) begin
        if (on_q[d] && IST[d] == SENSE[d]) begin
          dio_o[LINE[d]] = 1'b1;
        end
      end
    end else if (sp_mode && !atn_i && talker == DEV_A[1]) begin
      dio_o = ST_BYTE;
      dav_o = 1'b1;
    end
  end
endmodule

// File: bench/tb.sv
// self-checking bench of the controller interface
// assumes gci_ctrl and the bus model; one 10 MHz clock
`timescale 1ns/1ps
module tb
  import gci_pkg::*;
;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic sysctl = 1'b1;  // sole system controller on this bus
  logic ifc = 1'b0;
  logic [15:0] rdata;
  logic irq;
  logic srq;
  logic [7:0] d_out;
  logic [7:0] m_out;
  logic oe;
  logic atn;
  logic eoi;
  logic d_dav;
  logic m_dav;
  logic [15:0] r;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  gci_ctrl dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd_s), .rdata_o(rdata),
    .irq_o(irq), .sysctl_i(sysctl), .srq_i(srq), .ifc_i(ifc),
    .dio_i((oe ? d_out : 8'h00) | m_out), .dav_i(d_dav | m_dav),
    .dio_o(d_out), .dio_oe_o(oe), .atn_o(atn), .eoi_o(eoi),
    .dav_o(d_dav));
  gci_bus_model mdl_u (.clk_i(clk_i), .atn_i(atn), .eoi_i(eoi),
    .dav_i(d_dav), .dio_i(d_out), .dio_o(m_out), .dav_o(m_dav),
    .srq_o(srq));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask
  // issue a command and poll busy under a bounded count
  task automatic cmd(input logic [2:0] c, input logic [4:0] dv);
    wr_reg(GCI_REG_CMD, {5'h00, c, 3'h0, dv});
    repeat (3) @(posedge clk_i);
    for (int k = 0; k < 400; k++) begin
      rd_reg(GCI_REG_RESULT, r);
      if (r[9] === 1'b0) break;
    end
  endtask
  function automatic logic [7:0] last(input int back);
    return mdl_u.log_q[3'(mdl_u.n_log - back)];
  endfunction
  task automatic end_of_test;
    $display("counts: checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rd_reg(GCI_REG_CTRL, r);
    check(r, 16'h00d5);
    rd_reg(GCI_REG_MASK, r);
    check(r, GCI_MASK_RST);
    wr_reg(GCI_REG_CTRL, 16'h0021);
    rd_reg(GCI_REG_CTRL, r);
    check(r, 16'h00c1);
    wr_reg(GCI_REG_CTRL, 16'h001f);
    rd_reg(GCI_REG_CTRL, r);
    check(r, 16'h00de);
    wr_reg(GCI_REG_CTRL, 16'h003e);
    rd_reg(GCI_REG_CTRL, r);
    check(r, 16'h00de);
    wr_reg(4'hf, 16'hffff);
    rd_reg(4'hf, r);
    check(r, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_irq;
    wr_reg(GCI_REG_CAUSE, 16'h0002);
    rd_reg(GCI_REG_MASK, r);
    check(r, 16'h0002);
    // glitch between edges is never sampled
    @(posedge clk_i);
    #20 mdl_u.srq_o = 1'b1;
    #40 mdl_u.srq_o = 1'b0;
    repeat (6) @(posedge clk_i);
    check({15'h0, irq}, 16'h0000);
    rd_reg(GCI_REG_CAUSE, r);
    check(r, 16'h0000);
    wr_reg(GCI_REG_CAUSE, 16'h0003);
    mdl_u.srq_o <= 1'b1;
    for (int k = 0; k < 10 && irq !== 1'b1; k++) @(posedge clk_i);
    check({15'h0, irq}, 16'h0001);
    mdl_u.srq_o <= 1'b0;
    ifc <= 1'b1;
    repeat (4) @(posedge clk_i);
    ifc <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_reg(GCI_REG_CAUSE, r);
    check(r, 16'h0002);
    repeat (2) @(posedge clk_i);
    check({15'h0, irq}, 16'h0000);
    wr_reg(GCI_REG_CAUSE, 16'h0000);
    $display("test irq done");
  endtask
  task automatic t_parallel_status_query;
    mdl_u.configure(0);
    mdl_u.configure(1);
    cmd(GCI_CMD_PARALLEL_STATUS_QUERY, 5'h00);
    check(r, 16'h0081);
    cmd(GCI_CMD_PPU_DEV, 5'h05);
    check({8'h00, last(1)}, {8'h00, GCI_BUS_PPD});
    cmd(GCI_CMD_PARALLEL_STATUS_QUERY, 5'h00);
    check(r, 16'h0080);
    cmd(GCI_CMD_PPU_ALL, 5'h00);
    check({8'h00, last(1)}, {8'h00, GCI_BUS_PPU});
    cmd(GCI_CMD_PARALLEL_STATUS_QUERY, 5'h00);
    check(r, 16'h0000);
    $display("test parallel poll done");
  endtask
  task automatic t_spoll;
    cmd(GCI_CMD_SPOLL, 5'h09);
    check(r, 16'h0041);
    check({8'h00, last(1)}, {8'h00, GCI_BUS_SPD});
    cmd(GCI_CMD_SPOLL, GCI_ADDR_UNUSED);
    check({15'h0, r[8]}, 16'h0001);
    $display("test serial poll done");
  endtask
  task automatic t_pass;
    cmd(GCI_CMD_PASS, 5'h09);
    check({8'h00, last(2)}, {8'h00, GCI_BUS_TAG | 8'h09});
    check({8'h00, last(1)}, {8'h00, GCI_BUS_TCT});
    rd_reg(GCI_REG_CTRL, r);
    check(r, 16'h009e);
    cmd(GCI_CMD_PARALLEL_STATUS_QUERY, 5'h00);
    check({15'h0, r[8]}, 16'h0001);
    $display("test pass control done");
  endtask
  // ****************************************
  // hang guard and main sequence
  // ****************************************
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    t_regs();
    t_irq();
    t_parallel_status_query();
    t_spoll();
    t_pass();
    end_of_test();
  end
endmodule
